// file: headphone_path_control.sv
// Register bank and offset calibration sequencer for the headphone path.
// Assumes an APB master on clk_i; analog blocks sample the control outputs.
`default_nettype none
module headphone_path_control
    import headphone_path_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    // APB slave
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [11:0]   paddr_i,
    input  wire logic [31:0]   pwdata_i,
    input  wire logic [3:0]    pstrb_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    // Driver power state from the analog side
    input  wire logic          drivers_powered_i,
    // Analog controls
    output analog_ctrl_s       analog_ctrl_o,
    output channel_ctrl_s      left_headphone_driver_o,
    output channel_ctrl_s      right_headphone_driver_o,
    output logic               first_left_line_input_bypass_o,
    output logic               first_right_line_input_bypass_o,
    // Calibration
    output logic               cal_active_o,
    output logic [5:0]         cal_config_o,
    output logic               cal_store_o
);

    logic [7:0]  regs_reg [NUM_REGS];
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    cal_state_e  cal_state_reg;
    cal_state_e  cal_state_next;
    logic [15:0] step_cnt_reg;
    logic [5:0]  cfg_cnt_reg;
    logic        cal_done_reg;
    logic        cal_store_reg;
    logic        drivers_prev_reg;
    logic        cal_active_reg;
    analog_ctrl_s  analog_reg;
    channel_ctrl_s left_reg;
    channel_ctrl_s right_reg;
    logic        left_bypass_reg;
    logic        right_bypass_reg;

    // APB decode
    wire logic       access_w   = psel_i & penable_i;
    wire logic [7:0] index_w    = paddr_i[9:2];
    wire logic       aligned_w  = (paddr_i[1:0] == 2'h0) & (paddr_i[11:10] == 2'h0);
    wire logic       is_flags_w = aligned_w & (index_w == IDX_CAL_FLAGS);
    logic [NUM_REGS-1:0] hit_w;
    logic [7:0] idx_table [NUM_REGS];
    assign idx_table[SLOT_CP_POWER]      = IDX_CP_POWER;
    assign idx_table[SLOT_LEFT_TIER]     = IDX_LEFT_TIER;
    assign idx_table[SLOT_RIGHT_TIER]    = IDX_RIGHT_TIER;
    assign idx_table[SLOT_AMP_POWER]     = IDX_AMP_POWER;
    assign idx_table[SLOT_COMMON_MODE]   = IDX_COMMON_MODE;
    assign idx_table[SLOT_LEFT_ROUTE]    = IDX_LEFT_ROUTE;
    assign idx_table[SLOT_RIGHT_ROUTE]   = IDX_RIGHT_ROUTE;
    assign idx_table[SLOT_LEFT_GAIN]     = IDX_LEFT_GAIN;
    assign idx_table[SLOT_RIGHT_GAIN]    = IDX_RIGHT_GAIN;
    assign idx_table[SLOT_LEFT_LINE_AT]  = IDX_LEFT_LINE_AT;
    assign idx_table[SLOT_RIGHT_LINE_AT] = IDX_RIGHT_LINE_AT;
    assign idx_table[SLOT_LEFT_AMP_AT]   = IDX_LEFT_AMP_AT;
    assign idx_table[SLOT_RIGHT_AMP_AT]  = IDX_RIGHT_AMP_AT;
    assign idx_table[SLOT_CP_SIZING]     = IDX_CP_SIZING;
    assign idx_table[SLOT_CAL_CTRL]      = IDX_CAL_CTRL;

    wire logic any_hit_w  = |hit_w;
    wire logic mapped_w   = any_hit_w | is_flags_w;
    wire logic wr_err_w   = pwrite_i & is_flags_w;
    wire logic error_w    = ~mapped_w | wr_err_w;

    logic [7:0] read_byte_w;
    always_comb begin
        read_byte_w = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (hit_w[i]) begin
                read_byte_w = regs_reg[i];
            end
        end
        if (is_flags_w) begin
            read_byte_w = 8'h00;
            read_byte_w[CAL_DONE_BIT] = cal_done_reg;
        end
    end

    // Register file: one generate slot per register, written in the access phase
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : gen_reg
            assign hit_w[g] = aligned_w & (index_w == idx_table[g]);
            always_ff @(posedge clk_i) begin
                // reset defaults; contents held until written or reset
                if (!reset_n_i) begin
                    regs_reg[g] <= REG_RESET;
                end else if (access_w & pwrite_i & hit_w[g] & pstrb_i[0]) begin
                    regs_reg[g] <= pwdata_i[7:0];
                end
            end
        end
    endgenerate

    // Zero-wait APB answer, so pready sits high during every access phase
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= psel_i & ~penable_i;
            pslverr_reg <= psel_i & ~penable_i & error_w;
            prdata_reg  <= (psel_i & ~penable_i & ~pwrite_i) ? {24'h000000, read_byte_w}
                                                             : 32'h0000_0000;
        end
    end

    // Calibration control fields
    wire logic [1:0] cal_mode_w = regs_reg[SLOT_CAL_CTRL][CAL_MODE_LSB +: 2];
    wire logic       gc_w       = regs_reg[SLOT_CAL_CTRL][GROUND_CENTER_BIT];
    wire logic       cp_on_w    = regs_reg[SLOT_CP_POWER][CP_CTRL_LSB +: 2] == CP_ON_CODE;
    // ground-centered only counts with the pump running
    wire logic       gc_ok_w    = gc_w & cp_on_w;
    // start on driver power-up in ground-centered mode
    wire logic       power_up_w = drivers_powered_i & ~drivers_prev_reg;
    wire logic       start_w    = power_up_w & gc_ok_w & (cal_mode_w != CAL_OFF);
    wire logic [5:0] cfg_last_w = (cal_mode_w == CAL_ALL) ? 6'(CAL_CONFIGS - 1) : 6'h00;
    wire logic       step_end_w = step_cnt_reg == 16'(CAL_STEP_CYCLES - 1);
    wire logic       cfg_end_w  = cfg_cnt_reg >= cfg_last_w;

    always_comb begin
        cal_state_next = cal_state_reg;
        case (cal_state_reg)
            CAL_IDLE: begin
                if (start_w) begin
                    cal_state_next = CAL_RUN;
                end
            end
            CAL_RUN: begin
                // mode cleared or drivers dropped aborts the run
                if (cal_mode_w == CAL_OFF || !drivers_powered_i) begin
                    cal_state_next = CAL_IDLE;
                end else if (step_end_w & cfg_end_w) begin
                    cal_state_next = CAL_STORE;
                end
            end
            CAL_STORE: begin
                cal_state_next = CAL_DONE;
            end
            CAL_DONE: begin
                // Recalibrate on the next ground-centered power-up
                if (start_w) begin
                    cal_state_next = CAL_RUN;
                end
            end
            default: begin
                cal_state_next = CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cal_state_reg    <= CAL_IDLE;
            cal_active_reg   <= 1'b0;
            step_cnt_reg     <= 16'h0000;
            cfg_cnt_reg      <= 6'h00;
            cal_done_reg     <= 1'b0;
            cal_store_reg    <= 1'b0;
            drivers_prev_reg <= 1'b0;
        end else begin
            cal_state_reg    <= cal_state_next;
            // Registered copy of the run state keeps the output on a flop
            cal_active_reg   <= cal_state_next == CAL_RUN;
            drivers_prev_reg <= drivers_powered_i;
            cal_store_reg    <= cal_state_reg == CAL_STORE;
            if (cal_state_reg != CAL_RUN || step_end_w) begin
                step_cnt_reg <= 16'h0000;
            end else begin
                step_cnt_reg <= step_cnt_reg + 16'h0001;
            end
            if (cal_state_reg != CAL_RUN) begin
                cfg_cnt_reg <= 6'h00;
            end else if (step_end_w) begin
                cfg_cnt_reg <= cfg_cnt_reg + 6'h01;
            end
            // flag rises when results are stored, clears on a new run
            if (cal_state_reg == CAL_STORE) begin
                cal_done_reg <= 1'b1;
            end else if (cal_state_next == CAL_RUN) begin
                cal_done_reg <= 1'b0;
            end
        end
    end

    // Analog controls, registered so outputs come from flip-flops
    analog_ctrl_s  analog_next;
    channel_ctrl_s left_next;
    channel_ctrl_s right_next;
    always_comb begin
        // pump enable, rail grounded when off
        analog_next.cp_enable          = cp_on_w;
        analog_next.neg_rail_as_ground = ~cp_on_w;
        analog_next.cp_rate            = regs_reg[SLOT_CP_SIZING][CP_RATE_LSB +: 4];
        analog_next.cp_sizing          = regs_reg[SLOT_CP_SIZING][CP_SIZE_LSB +: 3];
        analog_next.hp_sizing          = regs_reg[SLOT_CAL_CTRL][HP_SIZE_LSB +: 2];
        analog_next.ground_centered    = gc_ok_w;
        // correction block off at mode 00
        analog_next.offset_corr_enable = cal_mode_w != CAL_OFF;
        analog_next.mixer_amp_power    = regs_reg[SLOT_AMP_POWER][AMP_POWER_LSB +: 2];
        analog_next.common_mode_level  = regs_reg[SLOT_COMMON_MODE][COMMON_MODE_BIT];
        analog_next.left_power_tier    = regs_reg[SLOT_LEFT_TIER][TIER_LSB +: 3];
        analog_next.right_power_tier   = regs_reg[SLOT_RIGHT_TIER][TIER_LSB +: 3];
        analog_next.left_low_perf      = regs_reg[SLOT_LEFT_TIER][LOW_PERF_BIT];
        analog_next.right_low_perf     = regs_reg[SLOT_RIGHT_TIER][LOW_PERF_BIT];
        left_next.route       = regs_reg[SLOT_LEFT_ROUTE];
        right_next.route      = regs_reg[SLOT_RIGHT_ROUTE];
        left_next.gain        = regs_reg[SLOT_LEFT_GAIN][GAIN_LSB +: 6];
        right_next.gain       = regs_reg[SLOT_RIGHT_GAIN][GAIN_LSB +: 6];
        left_next.line_atten  = regs_reg[SLOT_LEFT_LINE_AT];
        right_next.line_atten = regs_reg[SLOT_RIGHT_LINE_AT];
        left_next.amp_atten   = regs_reg[SLOT_LEFT_AMP_AT];
        right_next.amp_atten  = regs_reg[SLOT_RIGHT_AMP_AT];
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            analog_reg       <= '0;
            left_reg         <= '0;
            right_reg        <= '0;
            left_bypass_reg  <= 1'b0;
            right_bypass_reg <= 1'b0;
        end else begin
            analog_reg       <= analog_next;
            left_reg         <= left_next;
            right_reg        <= right_next;
            left_bypass_reg  <= regs_reg[SLOT_LEFT_ROUTE][LINE_BYPASS_BIT];
            right_bypass_reg <= regs_reg[SLOT_RIGHT_ROUTE][LINE_BYPASS_BIT];
        end
    end

    assign prdata_o                        = prdata_reg;
    assign pready_o                        = pready_reg;
    assign pslverr_o                       = pslverr_reg;
    assign analog_ctrl_o                   = analog_reg;
    assign left_headphone_driver_o         = left_reg;
    assign right_headphone_driver_o        = right_reg;
    assign first_left_line_input_bypass_o  = left_bypass_reg;
    assign first_right_line_input_bypass_o = right_bypass_reg;
    // sweep index and active flag for the analog trim
    assign cal_active_o                    = cal_active_reg;
    assign cal_config_o                    = cfg_cnt_reg;
    assign cal_store_o                     = cal_store_reg;

endmodule : headphone_path_control
`default_nettype wire

// file: headphone_path_pkg.sv
// Package for the headphone output path control block.
// Assumes an APB master with 32-bit data and word-aligned register slots.
`default_nettype none
package headphone_path_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CP_POWER      = 8'h01;
    localparam logic [7:0] IDX_CAL_FLAGS     = 8'h02;
    localparam logic [7:0] IDX_LEFT_TIER     = 8'h03;
    localparam logic [7:0] IDX_RIGHT_TIER    = 8'h04;
    localparam logic [7:0] IDX_AMP_POWER     = 8'h09;
    localparam logic [7:0] IDX_COMMON_MODE   = 8'h0A;
    localparam logic [7:0] IDX_LEFT_ROUTE    = 8'h0C;
    localparam logic [7:0] IDX_RIGHT_ROUTE   = 8'h0D;
    localparam logic [7:0] IDX_LEFT_GAIN     = 8'h10;
    localparam logic [7:0] IDX_RIGHT_GAIN    = 8'h11;
    localparam logic [7:0] IDX_LEFT_LINE_AT  = 8'h16;
    localparam logic [7:0] IDX_RIGHT_LINE_AT = 8'h17;
    localparam logic [7:0] IDX_LEFT_AMP_AT   = 8'h18;
    localparam logic [7:0] IDX_RIGHT_AMP_AT  = 8'h19;
    localparam logic [7:0] IDX_CP_SIZING     = 8'h7C;
    localparam logic [7:0] IDX_CAL_CTRL      = 8'h7D;

    // Register file slots
    localparam int NUM_REGS = 15;
    localparam int SLOT_CP_POWER      = 0;
    localparam int SLOT_LEFT_TIER     = 1;
    localparam int SLOT_RIGHT_TIER    = 2;
    localparam int SLOT_AMP_POWER     = 3;
    localparam int SLOT_COMMON_MODE   = 4;
    localparam int SLOT_LEFT_ROUTE    = 5;
    localparam int SLOT_RIGHT_ROUTE   = 6;
    localparam int SLOT_LEFT_GAIN     = 7;
    localparam int SLOT_RIGHT_GAIN    = 8;
    localparam int SLOT_LEFT_LINE_AT  = 9;
    localparam int SLOT_RIGHT_LINE_AT = 10;
    localparam int SLOT_LEFT_AMP_AT   = 11;
    localparam int SLOT_RIGHT_AMP_AT  = 12;
    localparam int SLOT_CP_SIZING     = 13;
    localparam int SLOT_CAL_CTRL      = 14;

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int CP_CTRL_LSB       = 0;
    localparam int CP_RATE_LSB       = 0;
    localparam int CP_SIZE_LSB       = 4;
    localparam int CAL_MODE_LSB      = 0;
    localparam int HP_SIZE_LSB       = 2;
    localparam int GROUND_CENTER_BIT = 4;
    localparam int CAL_DONE_BIT      = 2;
    localparam int LINE_BYPASS_BIT   = 2;
    localparam int COMMON_MODE_BIT   = 6;
    localparam int TIER_LSB          = 2;
    localparam int LOW_PERF_BIT      = 5;
    localparam int GAIN_LSB          = 0;
    localparam int AMP_POWER_LSB     = 0;

    // Field codes
    localparam logic [1:0] CP_ON_CODE   = 2'h2;
    localparam logic [1:0] CAL_OFF      = 2'h0;
    localparam logic [1:0] CAL_SELECTED = 2'h2;
    localparam logic [1:0] CAL_ALL      = 2'h3;
    localparam logic [5:0] GAIN_MUTE_CODE = 6'h3F;

    // Calibration timing
    localparam int CLK_HZ          = 25_000_000;
    localparam int CAL_STEP_US     = 100;
    localparam int CAL_STEP_CYCLES = (CAL_STEP_US * (CLK_HZ / 1_000_000));
    localparam int CAL_CONFIGS     = 4;

    typedef enum logic [1:0] {
        CAL_IDLE    = 2'b00,
        CAL_RUN     = 2'b01,
        CAL_STORE   = 2'b10,
        CAL_DONE    = 2'b11
    } cal_state_e;

    // Analog path control bundle
    typedef struct packed {
        logic       cp_enable;
        logic       neg_rail_as_ground;
        logic [3:0] cp_rate;
        logic [2:0] cp_sizing;
        logic [1:0] hp_sizing;
        logic       ground_centered;
        logic       offset_corr_enable;
        logic [1:0] mixer_amp_power;
        logic       common_mode_level;
        logic [2:0] left_power_tier;
        logic [2:0] right_power_tier;
        logic       left_low_perf;
        logic       right_low_perf;
    } analog_ctrl_s;

    typedef struct packed {
        logic [7:0] route;
        logic [5:0] gain;
        logic [7:0] line_atten;
        logic [7:0] amp_atten;
    } channel_ctrl_s;

endpackage : headphone_path_pkg
`default_nettype wire

// file: headphone_path_sva.sv
// Port checker for the headphone path control block.
// Assumes one clock domain and APB byte address four times the index.
`default_nettype none
module headphone_path_sva
    import headphone_path_pkg::*;
(
    // Clock and reset
    input wire logic         clk_i,
    input wire logic         reset_n_i,
    // APB
    input wire logic         psel_i,
    input wire logic         penable_i,
    input wire logic         pwrite_i,
    input wire logic [11:0]  paddr_i,
    input wire logic [31:0]  pwdata_i,
    input wire logic [3:0]   pstrb_i,
    input wire logic [31:0]  prdata_o,
    input wire logic         pready_o,
    input wire logic         pslverr_o,
    // Analog side
    input wire logic         drivers_powered_i,
    input wire analog_ctrl_s analog_ctrl_o,
    input wire logic         first_left_line_input_bypass_o,
    input wire logic         cal_active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic setup = psel_i & ~penable_i;
    wire logic wr    = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];

    property p_ready_follows; setup |=> pready_o; endproperty
    property p_ready_single; pready_o |=> !pready_o; endproperty
    property p_flag_ro; setup && pwrite_i && paddr_i == 12'h008 |=> pslverr_o; endproperty
    property p_pump_on;
        wr && paddr_i == 12'h004 && pwdata_i[1:0] == CP_ON_CODE |-> ##2 analog_ctrl_o.cp_enable;
    endproperty
    // Outputs lag release by one edge, so the first edge is skipped
    property p_rail_ground;
        $past(reset_n_i) |-> analog_ctrl_o.neg_rail_as_ground == !analog_ctrl_o.cp_enable;
    endproperty
    property p_rate;
        wr && paddr_i == 12'h1F0 |-> ##2 analog_ctrl_o.cp_rate == $past(pwdata_i[3:0], 2)
            && analog_ctrl_o.cp_sizing == $past(pwdata_i[6:4], 2);
    endproperty
    property p_off_mode;
        wr && paddr_i == 12'h1F4 && pwdata_i[1:0] == CAL_OFF
            |-> ##2 !analog_ctrl_o.offset_corr_enable;
    endproperty
    property p_bypass;
        wr && paddr_i == 12'h030 |-> ##2 first_left_line_input_bypass_o == $past(pwdata_i[2], 2);
    endproperty
    property p_flag_busy;
        setup && !pwrite_i && paddr_i == 12'h008 && cal_active_o |=> !prdata_o[CAL_DONE_BIT];
    endproperty
    property p_cal_start;
        $rose(drivers_powered_i) && analog_ctrl_o.cp_enable && analog_ctrl_o.ground_centered
            && analog_ctrl_o.offset_corr_enable |-> ##[1:2] cal_active_o;
    endproperty

    a_ready_follows: assert property (p_ready_follows) else $error("no ready after setup");
    a_ready_single: assert property (p_ready_single) else $error("ready held too long");
    a_flag_ro: assert property (p_flag_ro) else $error("flag write accepted");
    a_pump_on: assert property (p_pump_on) else $error("pump did not start");
    a_rail_ground: assert property (p_rail_ground) else $error("rail mode wrong");
    a_rate: assert property (p_rate) else $error("pump rate or sizing wrong");
    a_off_mode: assert property (p_off_mode) else $error("correction still on");
    a_bypass: assert property (p_bypass) else $error("bypass wrong");
    a_flag_busy: assert property (p_flag_busy) else $error("flag set while running");
    a_cal_start: assert property (p_cal_start) else $error("calibration did not start");

    c_cal_run: cover property ($rose(cal_active_o));
    c_error: cover property (pslverr_o);
    c_pump: cover property ($rose(analog_ctrl_o.cp_enable));
endmodule : headphone_path_sva

bind headphone_path_control headphone_path_sva i_headphone_path_sva (.clk_i, .reset_n_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
    .pslverr_o, .drivers_powered_i, .analog_ctrl_o, .first_left_line_input_bypass_o,
    .cal_active_o);
`default_nettype wire

// file: headphone_load_model.sv
// Headphone load and analog power sequencing model.
// Assumes the bench asks for driver power only after setup is done.
`default_nettype none
module headphone_load_model (
    // Clock
    input  wire logic       clk_i,
    // Power request and ramp length in cycles
    input  wire logic       power_req_i,
    input  wire logic [3:0] ramp_i,
    // Driver state
    output logic            drivers_powered_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] ramp_reg;
    always_ff @(posedge clk_i) begin
        if (!power_req_i) begin
            ramp_reg          <= 4'h0;
            drivers_powered_o <= 1'b0;
        end else if (ramp_reg == ramp_i) begin
            drivers_powered_o <= 1'b1;
        end else begin
            ramp_reg <= ramp_reg + 4'h1;
        end
    end
endmodule : headphone_load_model
`default_nettype wire

// file: headphone_path_control_test.sv
// Self-checking bench for the headphone path control block.
// Assumes the load model as far side and APB with idle cycles between transfers.
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module headphone_path_control_test
    import headphone_path_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic          clk_i = 1'b0;
    logic          reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0]   paddr_i;
    logic [31:0]   pwdata_i, prdata_o;
    logic [3:0]    pstrb_i, ramp_i;
    logic          power_req_i, drivers_powered_i, cal_active_o, cal_store_o;
    logic          first_left_line_input_bypass_o, first_right_line_input_bypass_o;
    analog_ctrl_s  analog_ctrl_o;
    channel_ctrl_s left_headphone_driver_o, right_headphone_driver_o;
    logic [5:0]    cal_config_o, cfg_max;
    int            n_fail = 0;
    int            comparisons = 0;
    int            act_cnt, store_cnt;
    localparam logic [7:0] RW_IDX [15] = '{IDX_CP_POWER, IDX_LEFT_TIER, IDX_RIGHT_TIER,
        IDX_AMP_POWER, IDX_COMMON_MODE, IDX_LEFT_ROUTE, IDX_RIGHT_ROUTE, IDX_LEFT_GAIN,
        IDX_RIGHT_GAIN, IDX_LEFT_LINE_AT, IDX_RIGHT_LINE_AT, IDX_LEFT_AMP_AT,
        IDX_RIGHT_AMP_AT, IDX_CP_SIZING, IDX_CAL_CTRL};
    // Negative gain steps assumed two's complement in the six-bit field
    localparam logic [7:0] GAIN_MINUS_6 = 8'h3A;
    localparam logic [7:0] GAIN_MINUS_5 = 8'h3B;

    headphone_path_control i_headphone_path_control (.clk_i, .reset_n_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
        .pslverr_o, .drivers_powered_i, .analog_ctrl_o, .left_headphone_driver_o,
        .right_headphone_driver_o, .first_left_line_input_bypass_o,
        .first_right_line_input_bypass_o, .cal_active_o, .cal_config_o, .cal_store_o);
    headphone_load_model i_headphone_load_model (.clk_i, .power_req_i, .ramp_i,
        .drivers_powered_o(drivers_powered_i));

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (cal_active_o === 1'b1) act_cnt <= act_cnt + 1;
        if (cal_active_o === 1'b1 && cal_config_o > cfg_max) cfg_max <= cal_config_o;
        if (cal_store_o === 1'b1) store_cnt <= store_cnt + 1;
    end

    function automatic logic [7:0] pat(input logic [7:0] idx);
        return idx ^ 8'hB6;
    endfunction : pat

    task automatic test_done();
        if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // Request held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] q, output logic e);
        int n;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= {2'b00, idx, 2'b00};
        pwdata_i  <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (pready_o !== 1'b1) begin
            n_fail++;
            test_done();
        end
        q = prdata_o[7:0];
        e = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        logic       e;
        apb(1'b1, idx, d, q, e);
        `CHK(e, 1'b0)
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] x);
        logic [7:0] q;
        logic       e;
        apb(1'b0, idx, 8'h00, q, e);
        `CHK(q, x)
    endtask : rd

    task automatic hw_reset();
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
    endtask : hw_reset

    task automatic t_reset_values();
        for (int i = 0; i < 15; i++) rd(RW_IDX[i], REG_RESET);
        rd(IDX_CAL_FLAGS, REG_RESET);
        `CHK(analog_ctrl_o.cp_enable, 1'b0)
        `CHK(analog_ctrl_o.neg_rail_as_ground, 1'b1)
    endtask : t_reset_values

    task automatic t_fields();
        logic [7:0] q;
        logic       e;
        for (int i = 0; i < 15; i++) wr(RW_IDX[i], pat(RW_IDX[i]));
        for (int i = 0; i < 15; i++) rd(RW_IDX[i], pat(RW_IDX[i]));
        `CHK(left_headphone_driver_o.route, pat(IDX_LEFT_ROUTE))
        `CHK(first_left_line_input_bypass_o, 1'(pat(IDX_LEFT_ROUTE) >> 2))
        `CHK(first_right_line_input_bypass_o, 1'(pat(IDX_RIGHT_ROUTE) >> 2))
        `CHK(left_headphone_driver_o.gain, 6'(pat(IDX_LEFT_GAIN)))
        `CHK(right_headphone_driver_o.gain, 6'(pat(IDX_RIGHT_GAIN)))
        `CHK(left_headphone_driver_o.line_atten, pat(IDX_LEFT_LINE_AT))
        `CHK(right_headphone_driver_o.amp_atten, pat(IDX_RIGHT_AMP_AT))
        `CHK(analog_ctrl_o.mixer_amp_power, 2'(pat(IDX_AMP_POWER)))
        `CHK(analog_ctrl_o.common_mode_level, 1'(pat(IDX_COMMON_MODE) >> 6))
        `CHK(analog_ctrl_o.left_power_tier, 3'(pat(IDX_LEFT_TIER) >> 2))
        `CHK(analog_ctrl_o.right_low_perf, 1'(pat(IDX_RIGHT_TIER) >> 5))
        `CHK(analog_ctrl_o.cp_rate, 4'(pat(IDX_CP_SIZING)))
        `CHK(analog_ctrl_o.hp_sizing, 2'(pat(IDX_CAL_CTRL) >> 2))
        apb(1'b0, 8'h05, 8'h00, q, e);
        `CHK({e, q}, 9'h100)
        apb(1'b1, IDX_CAL_FLAGS, 8'hFF, q, e);
        `CHK(e, 1'b1)
        rd(IDX_CAL_FLAGS, 8'h00);
        pstrb_i <= 4'h0;
        wr(IDX_LEFT_GAIN, 8'h00);
        pstrb_i <= 4'hF;
        rd(IDX_LEFT_GAIN, pat(IDX_LEFT_GAIN));
        wr(IDX_LEFT_GAIN, GAIN_MINUS_6);
        wr(IDX_LEFT_GAIN, GAIN_MINUS_5);
        wr(IDX_LEFT_GAIN, {2'h0, GAIN_MUTE_CODE});
        rd(IDX_LEFT_GAIN, {2'h0, GAIN_MUTE_CODE});
        `CHK(left_headphone_driver_o.gain, GAIN_MUTE_CODE)
    endtask : t_fields

    task automatic t_cal(input logic [1:0] mode, input logic [3:0] ramp, input int cfgs);
        logic [7:0] q;
        logic       e;
        int         n;
        hw_reset();
        wr(IDX_CP_POWER, {6'h00, CP_ON_CODE});
        wr(IDX_CAL_CTRL, 8'h10 | {6'h00, mode});
        `CHK(analog_ctrl_o.cp_enable, 1'b1)
        `CHK(analog_ctrl_o.neg_rail_as_ground, 1'b0)
        act_cnt = 0;
        store_cnt = 0;
        cfg_max = 6'h00;
        power_req_i <= 1'b1;
        ramp_i <= ramp;
        apb(1'b0, IDX_CAL_FLAGS, 8'h00, q, e);
        `CHK(q[CAL_DONE_BIT], 1'b0)
        `CHK(analog_ctrl_o.ground_centered, 1'b1)
        `CHK(analog_ctrl_o.offset_corr_enable, 1'(mode != CAL_OFF))
        n = 0;
        while (q[CAL_DONE_BIT] !== 1'b1 && n < 200 + 1000 * cfgs) begin
            apb(1'b0, IDX_CAL_FLAGS, 8'h00, q, e);
            n++;
        end
        `CHK(q[CAL_DONE_BIT], 1'(cfgs != 0))
        if (cfgs != 0 && q[CAL_DONE_BIT] !== 1'b1) test_done();
        `CHK(act_cnt, CAL_STEP_CYCLES * cfgs)
        `CHK(store_cnt, int'(cfgs != 0))
        `CHK(cfg_max, (cfgs == CAL_CONFIGS) ? 6'(CAL_CONFIGS - 1) : 6'h00)
        power_req_i <= 1'b0;
        rd(IDX_CAL_FLAGS, 8'(cfgs != 0) << CAL_DONE_BIT);
        hw_reset();
        rd(IDX_CAL_FLAGS, 8'h00);
    endtask : t_cal

    initial begin
        reset_n_i   = 1'b0;
        psel_i      = 1'b0;
        penable_i   = 1'b0;
        pwrite_i    = 1'b0;
        paddr_i     = 12'h000;
        pwdata_i    = 32'h0;
        pstrb_i     = 4'hF;
        power_req_i = 1'b0;
        ramp_i      = 4'h0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset_values();
        t_fields();
        t_cal(CAL_SELECTED, 4'h9, 1);
        t_cal(CAL_ALL, 4'h0, CAL_CONFIGS);
        t_cal(CAL_OFF, 4'h2, 0);
        test_done();
    end
endmodule : headphone_path_control_test
`default_nettype wire
